// ---- logic/gpps_port.v ----
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/1ps
`include "gpps_map.vh"
module gpps_port #(
    parameter PINS = 6
) (
    // clock and reset
    input wire clk_sys,
    input wire reset,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output wire pslverr,
    output reg [31:0] prdata,
    // port a pins, split into in, out and output enable (low = driving)
    input wire [PINS-1:0] portAPinIn,
    output wire [PINS-1:0] portAPinOut,
    output wire [PINS-1:0] portAPinOeN,
    // analog front end: high disables the digital input buffer
    output wire [PINS-1:0] portAInBufDisable,
    // port c pins five and six, peripheral use only here
    output wire portCPinFiveOut,
    output wire portCPinFiveOeN,
    output wire portCPinSixOut,
    output wire portCPinSixOeN,
    // peripheral output levels; their enables are register bits
    input wire progDataOut,
    input wire pwmThreeOut,
    input wire logicCellOneOut,
    input wire clkOutSignal,
    input wire numOscOneOut
);
    reg [PINS-1:0] portADirection_q;
    reg [PINS-1:0] portAOutputLatch_q;
    reg [PINS-1:0] portAAnalogSelect_q;
    reg [1:0] altPinSteering_q;
    reg [`GPPS_PEN_WIDTH-1:0] periphEnable_q;
    wire [PINS-1:0] pinSync;
    wire [PINS-1:0] pinLevelRead;
    wire [PINS-1:0] dirRead;
    wire setup;
    wire wrAccess;
    wire addrOk;
    wire logicOnC;
    wire oscOnC;
    wire logicOnA;
    wire oscOnA;
    reg [PINS-1:0] pinDrive;
    reg [PINS-1:0] pinDriveEn;

    // two flops per pin keep metastable pad levels out of the read path
    gpps_pin_sync #(
        .WIDTH(PINS)
    ) u_sync (
        .clk_sys(clk_sys),
        .reset(reset),
        .asyncIn(portAPinIn),
        .syncOut(pinSync)
    );

    // analog pins read zero even if the pad shows a mid-level
    assign pinLevelRead = pinSync & ~portAAnalogSelect_q;
    assign portAInBufDisable = portAAnalogSelect_q;
    assign dirRead = portADirection_q | ({{(PINS-1){1'b0}}, 1'b1} << `GPPS_INPUT_ONLY_PIN);

    // apb: zero wait states, unmapped addresses answer with an error
    assign setup = psel & ~penable;
    assign pready = 1'b1;
    assign addrOk = (paddr == `GPPS_OFF_PIN_LEVEL) || (paddr == `GPPS_OFF_DIRECTION) ||
        (paddr == `GPPS_OFF_LATCH) || (paddr == `GPPS_OFF_ANALOG) ||
        (paddr == `GPPS_OFF_STEERING) || (paddr == `GPPS_OFF_PERIPH_EN);
    assign pslverr = psel & penable & ~addrOk;
    assign wrAccess = psel & penable & pwrite & addrOk;

    always @(posedge clk_sys) begin
        if (reset) begin
            portADirection_q <= `GPPS_DIR_RESET;
            portAOutputLatch_q <= {PINS{1'b0}};
            portAAnalogSelect_q <= `GPPS_ANALOG_MASK;
            altPinSteering_q <= `GPPS_STEER_RESET;
            periphEnable_q <= {`GPPS_PEN_WIDTH{1'b0}};
        end else if (wrAccess) begin
            case (paddr)
                `GPPS_OFF_PIN_LEVEL: begin
                    // full-register write: pins not read, all six latch bits replaced
                    portAOutputLatch_q <= pwdata[PINS-1:0];
                end
                `GPPS_OFF_LATCH: begin
                    portAOutputLatch_q <= pwdata[PINS-1:0];
                end
                `GPPS_OFF_DIRECTION: begin
                    portADirection_q <= pwdata[PINS-1:0] | dirRead & 6'h08;
                end
                `GPPS_OFF_ANALOG: begin
                    portAAnalogSelect_q <= pwdata[PINS-1:0] & `GPPS_ANALOG_MASK;
                end
                `GPPS_OFF_STEERING: begin
                    altPinSteering_q <= pwdata[1:0];
                end
                `GPPS_OFF_PERIPH_EN: begin
                    periphEnable_q <= pwdata[`GPPS_PEN_WIDTH-1:0];
                end
                default: begin
                    periphEnable_q <= periphEnable_q;
                end
            endcase
        end
    end

    // read data is registered at setup so it is stable in the access phase
    always @(posedge clk_sys) begin
        if (reset) begin
            prdata <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            case (paddr)
                `GPPS_OFF_PIN_LEVEL: prdata <= {26'h000_0000, pinLevelRead};
                `GPPS_OFF_DIRECTION: prdata <= {26'h000_0000, dirRead};
                `GPPS_OFF_LATCH: prdata <= {26'h000_0000, portAOutputLatch_q & 6'h37};
                `GPPS_OFF_ANALOG: prdata <= {26'h000_0000, portAAnalogSelect_q};
                `GPPS_OFF_STEERING: prdata <= {30'h0000_0000, altPinSteering_q};
                `GPPS_OFF_PERIPH_EN: prdata <= {27'h000_0000, periphEnable_q};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // steering moves only the peripheral override, never the direction bits
    assign logicOnC = altPinSteering_q[`GPPS_BIT_LOGIC_SEL];
    assign oscOnC = altPinSteering_q[`GPPS_BIT_OSC_SEL];
    assign logicOnA = periphEnable_q[`GPPS_PEN_LOGIC] & ~logicOnC;
    assign oscOnA = periphEnable_q[`GPPS_PEN_OSC] & ~oscOnC;

    // per-pin output priority; analog select plays no part here
    always @* begin
        pinDrive = portAOutputLatch_q;
        pinDriveEn = ~portADirection_q;
        if (periphEnable_q[`GPPS_PEN_PROG_DATA]) begin
            pinDrive[0] = progDataOut;
            pinDriveEn[0] = 1'b1;
        end
        if (oscOnA) begin
            pinDrive[1] = numOscOneOut;
            pinDriveEn[1] = 1'b1;
        end
        if (logicOnA) begin
            pinDrive[2] = logicCellOneOut;
            pinDriveEn[2] = 1'b1;
        end else if (periphEnable_q[`GPPS_PEN_PWM]) begin
            pinDrive[2] = pwmThreeOut;
            pinDriveEn[2] = 1'b1;
        end
        if (periphEnable_q[`GPPS_PEN_CLKOUT]) begin
            pinDrive[4] = clkOutSignal;
            pinDriveEn[4] = 1'b1;
        end
        pinDrive[`GPPS_INPUT_ONLY_PIN] = 1'b0;
        pinDriveEn[`GPPS_INPUT_ONLY_PIN] = 1'b0;
    end

    assign portAPinOut = pinDrive;
    assign portAPinOeN = ~pinDriveEn;
    assign portCPinFiveOut = logicCellOneOut;
    assign portCPinFiveOeN = ~(logicOnC & periphEnable_q[`GPPS_PEN_LOGIC]);
    assign portCPinSixOut = numOscOneOut;
    assign portCPinSixOeN = ~(oscOnC & periphEnable_q[`GPPS_PEN_OSC]);
endmodule

// ---- logic/gpps_map.vh ----
`ifndef GPPS_MAP_VH
`define GPPS_MAP_VH
`define GPPS_OFF_PIN_LEVEL 12'h000
`define GPPS_OFF_DIRECTION 12'h004
`define GPPS_OFF_LATCH 12'h008
`define GPPS_OFF_ANALOG 12'h00C
`define GPPS_OFF_STEERING 12'h010
`define GPPS_OFF_PERIPH_EN 12'h014
`define GPPS_DIR_RESET 6'h3F
`define GPPS_ANALOG_MASK 6'h17
`define GPPS_STEER_MASK 8'h03
`define GPPS_STEER_RESET 2'h0
`define GPPS_BIT_LOGIC_SEL 1
`define GPPS_BIT_OSC_SEL 0
`define GPPS_INPUT_ONLY_PIN 3
`define GPPS_PEN_PROG_DATA 0
`define GPPS_PEN_PWM 1
`define GPPS_PEN_LOGIC 2
`define GPPS_PEN_CLKOUT 3
`define GPPS_PEN_OSC 4
`define GPPS_PEN_WIDTH 5
`endif

// ---- logic/gpps_pin_sync.v ----
`timescale 1ns/1ps
// two-stage synchroniser, one stage pair per pin
module gpps_pin_sync #(
    parameter WIDTH = 6
) (
    // clock and reset
    input wire clk_sys,
    input wire reset,
    // asynchronous levels in, synchronised levels out
    input wire [WIDTH-1:0] asyncIn,
    output wire [WIDTH-1:0] syncOut
);
    reg [WIDTH-1:0] stageOne_q;
    reg [WIDTH-1:0] stageTwo_q;
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            always @(posedge clk_sys) begin
                if (reset) begin
                    stageOne_q[i] <= 1'b0;
                    stageTwo_q[i] <= 1'b0;
                end else begin
                    stageOne_q[i] <= asyncIn[i];
                    stageTwo_q[i] <= stageOne_q[i];
                end
            end
        end
    endgenerate
    assign syncOut = stageTwo_q;
endmodule

// ---- verif/gpps_pin_model.sv ----
`timescale 1ns/1ps
module gpps_pin_model (
    // port side and outside source; a released pin follows the source
    input wire [5:0] pinOut,
    input wire [5:0] oeN,
    input wire [5:0] extDrive,
    output wire [5:0] pinIn
);
    assign pinIn = (oeN & extDrive) | (~oeN & pinOut);
endmodule

// ---- verif/gpps_port_checker.sv ----
`timescale 1ns/1ps
module gpps_port_checker #(parameter PINS = 6) (
    // watched ports
    input wire clk_sys,
    input wire reset,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire [PINS-1:0] portAPinOeN,
    input wire [PINS-1:0] portAInBufDisable,
    input wire portCPinFiveOut,
    input wire portCPinFiveOeN,
    input wire portCPinSixOeN,
    input wire logicCellOneOut
);
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    wire rdAcc = psel && penable && !pwrite;
    chk_pin3_idle: assert property (portAPinOeN[3]) else $error("pin 3 driven");
    chk_reset_state: assert property ($fell(reset) |-> portAPinOeN == 6'h3F &&
        portAInBufDisable == 6'h17 && portCPinFiveOeN && portCPinSixOeN) else $error("reset state");
    chk_analog_mask: assert property ((portAInBufDisable & 6'h28) == 6'h00)
        else $error("analog select on missing pin");
    chk_cell_c5: assert property (!portCPinFiveOeN |-> portCPinFiveOut == logicCellOneOut)
        else $error("pin c5 not logic cell");
    chk_level_read: assert property (rdAcc && paddr == 12'h000 |->
        (prdata[5:0] & $past(portAInBufDisable)) == 6'h00 && prdata[31:6] == 26'h0)
        else $error("analog pin read not zero");
    chk_steer_upper: assert property (rdAcc && paddr == 12'h010 |-> prdata[31:2] == 30'h0)
        else $error("steering upper bits set");
    chk_dir_bit3: assert property (rdAcc && paddr == 12'h004 |-> prdata[3])
        else $error("pin 3 direction reads zero");
    chk_latch_gap: assert property (rdAcc && paddr == 12'h008 |-> !prdata[3])
        else $error("latch bit 3 set");
    cover property (!portCPinFiveOeN);
    cover property (!portCPinSixOeN);
    cover property (rdAcc && paddr == 12'h000);
endmodule
bind gpps_port gpps_port_checker #(.PINS(PINS)) chk (.clk_sys(clk_sys), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .portAPinOeN(portAPinOeN), .portAInBufDisable(portAInBufDisable),
    .portCPinFiveOut(portCPinFiveOut), .portCPinFiveOeN(portCPinFiveOeN),
    .portCPinSixOeN(portCPinSixOeN), .logicCellOneOut(logicCellOneOut));

// ---- verif/tb_gpio_port_with_pin_steering.sv ----
`timescale 1ns/1ps
module tb_gpio_port_with_pin_steering;
    logic clk_sys = 1'h0, reset = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic errSeen = 1'h0;
    // peripheral levels: program data, pwm, logic cell, clock out, oscillator
    logic [4:0] per = 5'h00;
    logic pready, pslverr, c5, c5n, c6, c6n;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [5:0] pinIn, pinOut, oeN;
    int badCount = 0, nCompared = 0;
    // write address, write data, read address, expected read
    // analog select is cleared before any pin is turned into an output
    logic [39:0] rows [8] = '{40'h00CF_F00C_17, 40'h00C0_000C_00, 40'h010F_F010_03,
        40'h0040_0004_08, 40'h0083_F008_37, 40'h0002_A008_22, 40'h014F_F014_1F,
        40'h0140_0014_00};
    gpps_port dut (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .portAPinIn(pinIn), .portAPinOut(pinOut), .portAPinOeN(oeN),
        .portAInBufDisable(), .portCPinFiveOut(c5), .portCPinFiveOeN(c5n), .portCPinSixOut(c6),
        .portCPinSixOeN(c6n), .progDataOut(per[0]), .pwmThreeOut(per[1]),
        .logicCellOneOut(per[2]), .clkOutSignal(per[3]), .numOscOneOut(per[4]));
    gpps_pin_model far (.pinOut(pinOut), .oeN(oeN), .extDrive(6'h0C), .pinIn(pinIn));
    initial forever #12.5 clk_sys = ~clk_sys;
    task automatic wrapUp;
        if (badCount == 0 && nCompared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        nCompared++;
        if (got !== exp) $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        if (got !== exp) badCount++;
    endtask
    // a read compares its data against d, so expectations travel with the request
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk_sys);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'h1;
        do @(posedge clk_sys); while (pready !== 1'h1 && ++n < 16);
        errSeen = pslverr;
        if (pready !== 1'h1) cmp(32'h0, 32'h1);
        if (pready !== 1'h1) wrapUp();
        if (!w) cmp(prdata, d);
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic rst;
        reset <= 1'h1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'h0;
    endtask
    initial begin
        rst();
        foreach (rows[i]) begin
            xfer(1'h1, rows[i][39:28], {24'h0, rows[i][27:20]});
            xfer(1'h0, rows[i][19:8], {24'h0, rows[i][7:0]});
        end
        repeat (3) @(posedge clk_sys);
        xfer(1'h0, 12'h000, 32'h0000_002A);
        xfer(1'h1, 12'h00C, 32'h0000_0017);
        xfer(1'h0, 12'h000, 32'h0000_0028);
        cmp({20'h0, oeN, pinOut & ~oeN}, 32'h0000_0222);
        // peripheral levels differ from the latch so every override is visible
        per <= 5'h0F;
        xfer(1'h1, 12'h014, 32'h0000_001F);
        xfer(1'h1, 12'h00C, 32'h0000_0000);
        xfer(1'h0, 12'h000, 32'h0000_003F);
        xfer(1'h0, 12'h004, 32'h0000_0008);
        cmp({22'h0, c5n, c6n, c5, c6, pinOut}, 32'h0000_00B7);
        per <= 5'h0B;
        xfer(1'h1, 12'h010, 32'h0);
        xfer(1'h0, 12'h010, 32'h0);
        cmp({22'h0, c5n, c6n, c5, c6, pinOut}, 32'h0000_0331);
        xfer(1'h0, 12'h020, 32'h0);
        cmp({31'h0, errSeen}, 32'h0000_0001);
        rst();
        xfer(1'h0, 12'h004, 32'h0000_003F);
        xfer(1'h0, 12'h00C, 32'h0000_0017);
        xfer(1'h0, 12'h010, 32'h0);
        cmp({31'h0, errSeen}, 32'h0000_0000);
        wrapUp();
    end
endmodule
